// File: fbrw_bus.sv
/*
 * Device-side front end of a 16-bit parallel flash bus: asynchronous and
 * page reads, synchronous burst reads, word-load capture, erase command
 * detection, status-read steering and program/erase busy timing.
 * Assumes the array read port answers combinationally on ref_clk, and that
 * host pins are asynchronous and sampled here through two flops.
 */
// Behaviour
// - Low strobe follows a stable address.
// - Low address bits select word within page.
// - Outputs float when chip or output enable drops.
// - Ready timing follows the two configuration bits.
// - Burst first data after four clocks.
// - Burst address captured on clock with strobe.
// - Write address taken at strobe rising edge.
// - Write strobe is chip and write enable low.
// - Program takes 22 or 10 microseconds.
// - Sector erase takes 100 or 500 milliseconds.
// - Status plane reads status; operations refused.
`timescale 1ns/100ps
module fbrw_bus #(
    parameter int PROG_NORM_US = fbrw_pkg::T_PROG_NORM_US,
    parameter int PROG_FAST_US = fbrw_pkg::T_PROG_FAST_US,
    parameter int SEC_SMALL_US = fbrw_pkg::T_SEC_SMALL_US,
    parameter int SEC_LARGE_US = fbrw_pkg::T_SEC_LARGE_US,
    parameter int PLANE_US     = fbrw_pkg::T_SEC_LARGE_US,
    parameter int CHIP_US      = fbrw_pkg::T_SEC_LARGE_US
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce_n,
    input  wire logic                        oe_n,
    input  wire logic                        we_n,
    input  wire logic                        address_valid_strobe_n,
    input  wire logic                        flash_clk,
    input  wire logic [fbrw_pkg::ADDR_W-1:0] addr,
    input  wire logic [fbrw_pkg::DATA_W-1:0] dq_in,
    output logic      [fbrw_pkg::DATA_W-1:0] dq_out,
    output logic                             dq_oe,
    output logic                             ready,
    input  wire logic                        burst_en,
    input  wire logic                        burst_len4,
    input  wire logic                        page8,
    input  wire logic                        ready_timing_bit_hi,
    input  wire logic                        ready_timing_bit_lo,
    input  wire logic                        vpp_high,
    input  wire logic [3:0]                  status_plane_en,
    input  wire logic [fbrw_pkg::DATA_W-1:0] status_word,
    output logic      [fbrw_pkg::ADDR_W-1:0] arr_addr,
    input  wire logic [fbrw_pkg::DATA_W-1:0] arr_rd_data,
    output logic                             wr_valid,
    output logic      [fbrw_pkg::ADDR_W-1:0] wr_addr,
    output logic      [fbrw_pkg::DATA_W-1:0] wr_data,
    input  wire logic                        prog_start,
    output logic                             op_busy,
    output logic                             op_done,
    output logic                             op_refused,
    output logic      [2:0]                  op_kind
);

    localparam int AW = fbrw_pkg::ADDR_W;
    localparam int DW = fbrw_pkg::DATA_W;
    localparam int TW = fbrw_pkg::TIMER_W;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0]    ctl_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] dq_s;

    // Address and data groups may land skewed by one cycle; the host holds
    // them stable well beyond the strobes that qualify them.
    fbrw_sync #(.WIDTH(5), .RESET_VAL(5'h0f)) u_sync_ctl (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({flash_clk, address_valid_strobe_n, we_n, oe_n, ce_n}),
        .sync_out (ctl_s)
    );

    fbrw_sync #(.WIDTH(AW)) u_sync_addr (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (addr),
        .sync_out (addr_s)
    );

    fbrw_sync #(.WIDTH(DW)) u_sync_dq (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (dq_in),
        .sync_out (dq_s)
    );

    wire ce_on  = ~ctl_s[0];
    wire oe_on  = ~ctl_s[1];
    wire we_on  = ~ctl_s[2];
    wire avd_on = ~ctl_s[3];
    wire fclk   = ctl_s[4];

    // ------------------------------------------------------------------
    // Edge history
    // ------------------------------------------------------------------
    logic fclk_reg;
    logic avd_reg;
    logic strobe_reg;

    wire strobe_on  = ce_on & we_on;
    wire strobe_beg = strobe_on & ~strobe_reg;
    wire strobe_end = ~strobe_on & strobe_reg;
    wire avd_rise   = ~avd_on & avd_reg;
    wire fclk_rise  = fclk & ~fclk_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fclk_reg   <= 1'b0;
            avd_reg    <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            fclk_reg   <= fclk;
            avd_reg    <= avd_on;
            strobe_reg <= strobe_on;
        end
    end

    // ------------------------------------------------------------------
    // Asynchronous and page read addressing
    // ------------------------------------------------------------------
    logic [AW-1:0] rd_latch_reg;
    logic [AW-1:0] rd_latch_next;

    // Transparent while the strobe is low, so a strobe tied low gives
    // flow-through reads and no clock edge is ever needed.
    assign rd_latch_next = avd_on ? addr_s : rd_latch_reg;

    wire [AW-1:0] page_mask = page8 ? fbrw_pkg::PAGE8_MASK : fbrw_pkg::PAGE4_MASK;
    wire [AW-1:0] async_addr = (rd_latch_reg & ~page_mask) | (addr_s & page_mask);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_latch_reg <= '0;
        end else begin
            rd_latch_reg <= rd_latch_next;
        end
    end

    // ------------------------------------------------------------------
    // Burst read engine
    // ------------------------------------------------------------------
    fbrw_pkg::fbrw_burst_t br_reg;
    fbrw_pkg::fbrw_burst_t br_next;
    logic [AW-1:0]         br_addr_reg;
    logic [2:0]            br_cnt_reg;

    wire br_capture = burst_en & fclk_rise & avd_on & ce_on;
    wire lat_last   = (br_cnt_reg == fbrw_pkg::BURST_LATENCY - 3'h1);
    wire len_last   = burst_len4 & (br_cnt_reg == fbrw_pkg::BURST_LEN4 - 3'h1);
    wire br_active  = (br_reg == fbrw_pkg::FBRW_BR_DATA);

    always_comb begin
        br_next = br_reg;
        unique case (br_reg)
            fbrw_pkg::FBRW_BR_IDLE: begin
                if (br_capture) begin
                    br_next = fbrw_pkg::FBRW_BR_LAT;
                end
            end
            fbrw_pkg::FBRW_BR_LAT: begin
                if (fclk_rise && lat_last) begin
                    br_next = fbrw_pkg::FBRW_BR_DATA;
                end
            end
            fbrw_pkg::FBRW_BR_DATA: begin
                if (fclk_rise && len_last) begin
                    br_next = fbrw_pkg::FBRW_BR_DONE;
                end
            end
            fbrw_pkg::FBRW_BR_DONE: begin
                br_next = fbrw_pkg::FBRW_BR_DONE;
            end
        endcase
        if (!ce_on) begin
            br_next = fbrw_pkg::FBRW_BR_IDLE;
        end else if (br_capture) begin
            br_next = fbrw_pkg::FBRW_BR_LAT;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            br_reg      <= fbrw_pkg::FBRW_BR_IDLE;
            br_addr_reg <= '0;
            br_cnt_reg  <= '0;
        end else begin
            br_reg <= br_next;
            if (br_capture) begin
                br_addr_reg <= addr_s;
                br_cnt_reg  <= '0;
            end else if (fclk_rise && br_reg == fbrw_pkg::FBRW_BR_LAT) begin
                br_cnt_reg <= lat_last ? 3'h0 : br_cnt_reg + 3'h1;
            end else if (fclk_rise && br_active) begin
                br_addr_reg <= br_addr_reg + 1'b1;
                br_cnt_reg  <= br_cnt_reg + 3'h1;
            end
        end
    end

    // Ready: the high bit pulls assertion one clock ahead of data; the low
    // bit flips the pin polarity.
    wire ready_early = ready_timing_bit_hi & (br_reg == fbrw_pkg::FBRW_BR_LAT) & lat_last;
    wire ready_act   = ~burst_en | br_active | ready_early;
    wire ready_pin   = ready_act ^ ready_timing_bit_lo;

    // ------------------------------------------------------------------
    // Read data path and status steering
    // ------------------------------------------------------------------
    assign arr_addr = (br_reg == fbrw_pkg::FBRW_BR_IDLE) ? async_addr : br_addr_reg;

    wire [1:0]    rd_plane = arr_addr[fbrw_pkg::PLANE_LSB +: 2];
    wire [DW-1:0] rd_word  = status_plane_en[rd_plane] ? status_word : arr_rd_data;
    wire          out_on   = ce_on & oe_on & ~we_on;
    wire          dq_load  = burst_en ? (fclk_rise & br_active) : 1'b1;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe  <= 1'b0;
            ready  <= 1'b1;
        end else begin
            dq_oe <= out_on;
            ready <= ready_pin;
            if (dq_load) begin
                dq_out <= rd_word;
            end
        end
    end

    // ------------------------------------------------------------------
    // Word-load capture
    // ------------------------------------------------------------------
    logic avd_held_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr      <= '0;
            wr_data      <= '0;
            wr_valid     <= 1'b0;
            avd_held_reg <= 1'b0;
        end else begin
            wr_valid <= strobe_end;
            if (avd_rise && ce_on && !burst_en) begin
                wr_addr      <= addr_s;
                avd_held_reg <= 1'b1;
            end else if (strobe_beg && !avd_held_reg) begin
                wr_addr <= addr_s;
            end else if (strobe_end) begin
                avd_held_reg <= 1'b0;
            end
            if (strobe_end) begin
                wr_data <= dq_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // Erase detection and operation launch
    // ------------------------------------------------------------------
    wire [7:0] wr_code   = wr_data[7:0];
    wire       small_sec = (wr_addr[AW-1:fbrw_pkg::SMALL_SEC_LSB] == fbrw_pkg::SMALL_SEC_TAG);
    wire       hit_chip  = (wr_code == fbrw_pkg::CODE_CHIP_ERASE);
    wire       hit_plane = (wr_code == fbrw_pkg::CODE_PLANE_ERASE);
    wire       hit_sec   = (wr_code == fbrw_pkg::CODE_SECTOR_ERASE);
    wire       erase_req = wr_valid & (hit_chip | hit_plane | hit_sec);
    wire       start_req = erase_req | prog_start;
    wire       blocked   = op_busy | (|status_plane_en);
    wire       launch    = start_req & ~blocked;

    // The chip erase address is not checked; a wrong address still erases.
    fbrw_pkg::fbrw_op_t kind_next;
    logic [TW-1:0]      dur_us;

    always_comb begin
        kind_next = fbrw_pkg::FBRW_OP_PROGRAM;
        if (erase_req && hit_chip) begin
            kind_next = fbrw_pkg::FBRW_OP_CHIP;
        end else if (erase_req && hit_plane) begin
            kind_next = fbrw_pkg::FBRW_OP_PLANE;
        end else if (erase_req) begin
            kind_next = small_sec ? fbrw_pkg::FBRW_OP_SEC_SMALL : fbrw_pkg::FBRW_OP_SEC_LARGE;
        end
    end

    always_comb begin
        dur_us = TW'(vpp_high ? PROG_FAST_US : PROG_NORM_US);
        unique case (kind_next)
            fbrw_pkg::FBRW_OP_SEC_SMALL: dur_us = TW'(SEC_SMALL_US);
            fbrw_pkg::FBRW_OP_SEC_LARGE: dur_us = TW'(SEC_LARGE_US);
            fbrw_pkg::FBRW_OP_PLANE:     dur_us = TW'(PLANE_US);
            fbrw_pkg::FBRW_OP_CHIP:      dur_us = TW'(CHIP_US);
            default:                     dur_us = TW'(vpp_high ? PROG_FAST_US : PROG_NORM_US);
        endcase
    end

    fbrw_op_timer u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (launch),
        .load_us (dur_us),
        .busy    (op_busy),
        .done    (op_done)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_refused <= 1'b0;
            op_kind    <= 3'h0;
        end else begin
            op_refused <= start_req & blocked;
            if (launch) begin
                op_kind <= kind_next;
            end
        end
    end

endmodule : fbrw_bus

// File: fbrw_pkg.sv
/*
 * Shared constants for the flash bus read/write front end: widths, address
 * fields, command codes, burst figures and operation durations.
 * Assumes a 250 MHz ref_clk and a 22-bit word address, 16-bit data bus.
 */
package fbrw_pkg;

    // ------------------------------------------------------------------
    // Widths and address fields
    // ------------------------------------------------------------------
    localparam int ADDR_W        = 22;
    localparam int DATA_W        = 16;
    localparam int PLANE_LSB     = 20;
    localparam int SMALL_SEC_LSB = 15;
    localparam logic [6:0]  SMALL_SEC_TAG   = 7'h7f;
    localparam logic [ADDR_W-1:0] PAGE4_MASK = 22'h00_0003;
    localparam logic [ADDR_W-1:0] PAGE8_MASK = 22'h00_0007;
    localparam logic [11:0] CHIP_ERASE_ADDR = 12'h555;

    // ------------------------------------------------------------------
    // Command words
    // ------------------------------------------------------------------
    localparam logic [7:0] CODE_CHIP_ERASE   = 8'h10;
    localparam logic [7:0] CODE_PLANE_ERASE  = 8'h20;
    localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;

    // ------------------------------------------------------------------
    // Burst figures
    // ------------------------------------------------------------------
    localparam logic [2:0] BURST_LATENCY = 3'h4;
    localparam logic [2:0] BURST_LEN4    = 3'h4;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ          = 250;
    localparam int US_CYCLES        = CLK_MHZ;
    localparam int T_PROG_NORM_US   = 22;
    localparam int T_PROG_FAST_US   = 10;
    localparam int T_SEC_SMALL_MS   = 100;
    localparam int T_SEC_LARGE_MS   = 500;
    localparam int T_SEC_SMALL_US   = T_SEC_SMALL_MS * 1000;
    localparam int T_SEC_LARGE_US   = T_SEC_LARGE_MS * 1000;
    localparam int TIMER_W          = 20;
    localparam int PRESCALE_W       = 8;

    typedef enum logic [1:0] {
        FBRW_BR_IDLE = 2'b00,
        FBRW_BR_LAT  = 2'b01,
        FBRW_BR_DATA = 2'b10,
        FBRW_BR_DONE = 2'b11
    } fbrw_burst_t;

    typedef enum logic [2:0] {
        FBRW_OP_PROGRAM   = 3'b000,
        FBRW_OP_SEC_SMALL = 3'b001,
        FBRW_OP_SEC_LARGE = 3'b010,
        FBRW_OP_PLANE     = 3'b011,
        FBRW_OP_CHIP      = 3'b100
    } fbrw_op_t;

endpackage : fbrw_pkg

// File: fbrw_sync.sv
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes each bit is a level that stays put for several ref_clk cycles.
 */
`timescale 1ns/100ps
module fbrw_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // --------------------------------------------------------------
    // The first stage feeds only the second.
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : fbrw_sync

// File: fbrw_op_timer.sv
/*
 * Busy timer for program and erase operations, counted in microseconds.
 * Assumes load is a one-cycle pulse taken only while idle.
 */
`timescale 1ns/100ps
module fbrw_op_timer (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        load,
    input  wire logic [fbrw_pkg::TIMER_W-1:0] load_us,
    output logic                             busy,
    output logic                             done
);

    localparam logic [fbrw_pkg::PRESCALE_W-1:0] PRE_TOP =
        fbrw_pkg::PRESCALE_W'(fbrw_pkg::US_CYCLES - 1);

    logic [fbrw_pkg::PRESCALE_W-1:0] pre_reg;
    logic [fbrw_pkg::TIMER_W-1:0]    us_reg;
    wire                             us_tick = (pre_reg == PRE_TOP);
    wire                             last_us = (us_reg == fbrw_pkg::TIMER_W'(1));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
            us_reg  <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load && !busy) begin
                pre_reg <= '0;
                us_reg  <= load_us;
                busy    <= 1'b1;
            end else if (busy) begin
                pre_reg <= us_tick ? '0 : pre_reg + 1'b1;
                if (us_tick) begin
                    us_reg <= us_reg - 1'b1;
                    if (last_us) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            end
        end
    end

endmodule : fbrw_op_timer

// File: fbrw_bus_monitor.sv
/*
 * Port checker for fbrw_bus, bound to every instance of it.
 * Assumes host pins reach the logic through two flops on ref_clk.
 */
`timescale 1ns/100ps
module fbrw_bus_monitor (
    input wire logic                        ref_clk,
    input wire logic                        rst_n,
    input wire logic                        ce_n,
    input wire logic                        oe_n,
    input wire logic                        we_n,
    input wire logic                        dq_oe,
    input wire logic                        ready,
    input wire logic                        burst_en,
    input wire logic                        ready_timing_bit_lo,
    input wire logic [3:0]                  status_plane_en,
    input wire logic                        wr_valid,
    input wire logic [fbrw_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [fbrw_pkg::DATA_W-1:0] wr_data,
    input wire logic                        prog_start,
    input wire logic                        op_busy,
    input wire logic                        op_done,
    input wire logic                        op_refused,
    input wire logic [2:0]                  op_kind
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_oe_drive: assert property (!ce_n && !oe_n && we_n |-> ##3 dq_oe)
        else $error("bus not driven");
    chk_oe_float: assert property (ce_n || oe_n |-> ##3 !dq_oe)
        else $error("bus not released");
    chk_wr_single: assert property (wr_valid |=> !wr_valid)
        else $error("long load pulse");
    chk_wr_hold: assert property (!wr_valid |-> $stable(wr_data))
        else $error("load data moved");
    chk_busy_min: assert property ($rose(op_busy) |-> op_busy [*8])
        else $error("busy too short");
    chk_done_end: assert property (op_done |-> !op_busy && $past(op_busy))
        else $error("stray done");
    chk_refuse_busy: assert property (prog_start && (op_busy || |status_plane_en)
        |=> op_refused && !$rose(op_busy))
        else $error("not refused");
    chk_kind_hold: assert property (op_busy && $past(op_busy) |-> $stable(op_kind))
        else $error("kind changed");
    chk_ready_idle: assert property ((!burst_en && !ready_timing_bit_lo) [*5] |-> ready)
        else $error("ready low");
endmodule : fbrw_bus_monitor

bind fbrw_bus fbrw_bus_monitor u_mon (.*);

// File: fbrw_host.sv
/*
 * Host controller model driving the flash bus pins.
 * Assumes ref_clk at 250 MHz; every pin change follows a rising edge.
 */
`timescale 1ns/100ps
module fbrw_host (
    input wire logic                    ref_clk,
    output logic                        ce_n = 1'b1,
    output logic                        oe_n = 1'b1,
    output logic                        we_n = 1'b1,
    output logic                        address_valid_strobe_n = 1'b1,
    output logic                        flash_clk = 1'b0,
    output logic [fbrw_pkg::ADDR_W-1:0] addr = '0,
    output logic [fbrw_pkg::DATA_W-1:0] dq_in = '1
);

    // Address is held for the whole step, strobe low or not.
    task automatic drive(input logic c, o, w, s, input logic [21:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        ce_n <= c;
        oe_n <= o;
        we_n <= w;
        address_valid_strobe_n <= s;
        addr <= a;
        dq_in <= d;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : drive

    // One burst clock period, long enough for the two-flop sampling.
    task automatic edge_clk;
        @(posedge ref_clk) flash_clk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        flash_clk <= 1'b0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : edge_clk

    // Strobe-latched word load; released lines show inverted values.
    task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic ce_ctl);
        drive(1'b0, 1'b1, 1'b1, 1'b0, a, ~d);
        drive(1'b0, 1'b1, 1'b1, 1'b1, a, ~d);
        drive(ce_ctl, 1'b1, 1'b0, 1'b1, ~a, d);
        drive(1'b0, 1'b1, 1'b0, 1'b1, ~a, d);
        drive(ce_ctl, 1'b1, !ce_ctl, 1'b1, ~a, d);
        drive(1'b1, 1'b1, 1'b1, 1'b1, ~a, ~d);
    endtask : wr
endmodule : fbrw_host

// File: fbrw_bus_bench.sv
/*
 * Self-checking bench for fbrw_bus with a host model and an array model.
 * Assumes durations shortened to a few microseconds through parameters.
 */
`timescale 1ns/100ps
module fbrw_bus_bench;
    localparam int PN = 3, PF = 2, SS = 2, SL = 4, PL = 5, CH = 5;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce_n, oe_n, we_n, address_valid_strobe_n, flash_clk, dq_oe, ready, wr_valid;
    logic op_busy, op_done, op_refused;
    logic [fbrw_pkg::ADDR_W-1:0] addr, arr_addr, wr_addr;
    logic [fbrw_pkg::DATA_W-1:0] dq_in, dq_out, wr_data, arr_rd_data;
    logic [fbrw_pkg::DATA_W-1:0] status_word = 16'h5ac3;
    logic [3:0] status_plane_en = 4'h0;
    logic [2:0] op_kind;
    logic burst_en = 1'b0, burst_len4 = 1'b1, page8 = 1'b0, vpp_high = 1'b0, prog_start = 1'b0;
    logic ready_timing_bit_hi = 1'b0, ready_timing_bit_lo = 1'b0;
    int n_errors = 0, tests_run = 0, busy_cnt = 0, n_wr = 0, n_ref = 0;

    always #2 ref_clk = ~ref_clk;
    assign arr_rd_data = arr_addr[15:0] ^ 16'ha5a5;
    always @(posedge ref_clk) begin
        if (op_busy === 1'b1) busy_cnt <= busy_cnt + 1;
        if (wr_valid === 1'b1) n_wr <= n_wr + 1;
        if (op_refused === 1'b1) n_ref <= n_ref + 1;
    end

    fbrw_host host (.*);
    fbrw_bus #(.PROG_NORM_US(PN), .PROG_FAST_US(PF), .SEC_SMALL_US(SS), .SEC_LARGE_US(SL),
        .PLANE_US(PL), .CHIP_US(CH)) dut (.*);

    function automatic logic [15:0] exp_word(input logic [21:0] a);
        return a[15:0] ^ 16'ha5a5;
    endfunction : exp_word

    task automatic cmp_v(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_v

    task automatic cmp_n(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : cmp_n

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    task automatic start_prog;
        repeat (4) @(posedge ref_clk);
        prog_start <= 1'b1;
        @(posedge ref_clk) prog_start <= 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : start_prog

    // Waits a bounded time, since a hung timer must not stall the run.
    task automatic op_wait(input logic [2:0] k, input int n, input int b0);
        int i;
        for (i = 0; i < 1400 && op_done !== 1'b1; i++) @(negedge ref_clk);
        if (i == 1400) begin
            n_errors++;
            test_done();
        end
        cmp_n("busy cycles", n * fbrw_pkg::US_CYCLES, busy_cnt - b0);
        cmp_v("operation kind", k, op_kind);
    endtask : op_wait

    task automatic rd(input logic c, o, s, input logic [21:0] a);
        host.drive(c, o, 1'b1, s, a, 16'hffff);
    endtask : rd

    task automatic t_async;
        rd(1'b0, 1'b0, 1'b0, 22'h01_2345);
        cmp_v("async data", exp_word(22'h01_2345), dq_out);
        cmp_v("bus driven", 1'b1, dq_oe);
        @(posedge ref_clk) status_plane_en <= 4'h2;
        rd(1'b0, 1'b0, 1'b0, 22'h10_0abc);
        cmp_v("status read", status_word, dq_out);
        rd(1'b0, 1'b0, 1'b0, 22'h01_2345);
        cmp_v("other plane", exp_word(22'h01_2345), dq_out);
        @(posedge ref_clk) status_plane_en <= 4'h0;
        rd(1'b0, 1'b1, 1'b0, 22'h01_2345);
        cmp_v("float on oe", 1'b0, dq_oe);
        rd(1'b1, 1'b0, 1'b0, 22'h01_2345);
        cmp_v("float on ce", 1'b0, dq_oe);
    endtask : t_async

    task automatic t_page;
        logic [21:0] a, m;
        for (int p = 0; p < 2; p++) begin
            a = 22'h2a_5551 + p;
            m = p ? fbrw_pkg::PAGE8_MASK : fbrw_pkg::PAGE4_MASK;
            @(posedge ref_clk) page8 <= p[0];
            rd(1'b0, 1'b0, 1'b0, a);
            rd(1'b0, 1'b0, 1'b1, a);
            rd(1'b0, 1'b0, 1'b1, ~a);
            cmp_v("page word", exp_word((a & ~m) | (~a & m)), dq_out);
        end
    endtask : t_page

    task automatic t_burst;
        @(posedge ref_clk) burst_en <= 1'b1;
        ready_timing_bit_hi <= 1'b1;
        rd(1'b0, 1'b0, 1'b0, 22'h15_00fe);
        host.edge_clk();
        rd(1'b0, 1'b0, 1'b1, ~22'h15_00fe);
        repeat (3) host.edge_clk();
        cmp_v("early ready", 1'b1, ready);
        host.edge_clk();
        for (int i = 0; i < 5; i++) begin
            host.edge_clk();
            cmp_v("burst word", exp_word(22'h15_00fe + (i < 4 ? i : 3)), dq_out);
            if (i == 0) cmp_v("burst ready", 1'b1, ready);
        end
        rd(1'b1, 1'b1, 1'b1, 22'h15_00fe);
        @(posedge ref_clk) burst_en <= 1'b0;
        ready_timing_bit_hi <= 1'b0;
    endtask : t_burst

    task automatic t_write;
        int w0;
        for (int c = 0; c < 2; c++) begin
            w0 = n_wr;
            host.wr(22'h0a_0f0f + c, 16'h3c00 + c, c[0]);
            cmp_n("load pulses", 1, n_wr - w0);
            cmp_v("load address", 22'h0a_0f0f + c, wr_addr);
            cmp_v("load data", 16'h3c00 + c, wr_data);
        end
    endtask : t_write

    task automatic t_ops;
        logic [21:0] ea [4] = '{22'h3f_8123, 22'h10_8000, 22'h20_0000, 22'h00_0555};
        logic [7:0] ed [4] = '{8'h30, 8'h30, 8'h20, 8'h10};
        int en [4] = '{SS, SL, PL, CH};
        int b0, r0;
        for (int v = 0; v < 2; v++) begin
            @(posedge ref_clk) vpp_high <= v[0];
            b0 = busy_cnt;
            r0 = n_ref;
            start_prog();
            start_prog();
            cmp_n("refused while busy", 1, n_ref - r0);
            op_wait(3'h0, v ? PF : PN, b0);
        end
        for (int e = 0; e < 4; e++) begin
            b0 = busy_cnt;
            host.wr(ea[e], {8'h00, ed[e]}, e[0]);
            op_wait(3'(e + 1), en[e], b0);
        end
        @(posedge ref_clk) status_plane_en <= 4'h8;
        r0 = n_ref;
        start_prog();
        cmp_n("refused in status", 1, n_ref - r0);
        cmp_v("nothing started", 1'b0, op_busy);
        @(posedge ref_clk) status_plane_en <= 4'h0;
    endtask : t_ops

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_async();
        t_page();
        t_burst();
        t_write();
        t_ops();
        test_done();
    end
endmodule : fbrw_bus_bench
